/* hw/temp_pkg.sv */
// Purpose: shared constants and types for the temperature result back end
// Assumes: results arrive as signed 1/16 degree samples from the front end
// Notes:
// Operation
// - result high byte is whole degrees
// - low byte upper nibble sixteenths, low nibble zero
// - standard format clamps negatives to zero
// - extended format code zero means minus 64
// - filter levels average four or eight samples
// - remote result register holds filter output
// - limits compare against filtered remote value
// - filter level register, disabled after reset
// - fault comparator sampled during conversion sets flag
// - shorted diode reports minus 64 code
// - violation count field selects one to four
// - shutdown finishes current conversion then stops
// - shutdown clear converts continuously
// - registers stay accessible in shutdown
// - range change applies from next conversion
// - standard format saturates above 127 to 7Fh
// - extended byte is whole degrees plus 40h
// - one-shot write in shutdown runs one conversion
package temp_pkg;

    localparam int SAMPLE_W      = 16;            // signed, 1/16 degree per lsb
    localparam int FRAC_BITS     = 4;
    localparam int HIST_DEPTH    = 8;
    localparam logic [7:0] STD_MAX     = 8'h7F;
    localparam logic [7:0] EXT_OFFSET  = 8'h40;
    localparam logic [7:0] EXT_MAX     = 8'hFF;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    localparam logic [3:0] LOW_NIBBLE  = 4'h0;
    localparam logic [1:0] FILT_OFF    = 2'h0;
    localparam logic [1:0] FILT_L1     = 2'h1;
    localparam logic [1:0] FILT_L2     = 2'h2;
    localparam logic [2:0] CNT_ONE     = 3'h0;
    localparam logic [2:0] CNT_TWO     = 3'h1;
    localparam logic [2:0] CNT_THREE   = 3'h3;
    localparam logic [2:0] CNT_FOUR    = 3'h7;
    localparam int STATUS_OPEN_BIT = 2;
    localparam int CFG_RANGE_BIT   = 2;
    localparam int CFG_SD_BIT      = 6;

    typedef struct packed {
        logic [7:0] whole;
        logic [7:0] frac;
    } result_t;

    typedef struct packed {
        logic                       valid;
        logic signed [SAMPLE_W-1:0] temp;
    } sample_t;

endpackage

/* hw/temp_format.sv */
// Purpose: converts a signed sixteenth degree value into the two result bytes
// Assumes: combinational, used for both channels
// Notes: range flag selects standard or offset extended binary
`timescale 1ns/10ps
module temp_format (
    // value in
    input  wire logic signed [temp_pkg::SAMPLE_W-1:0] temp,
    input  wire logic                                 extended,
    // formatted out
    output temp_pkg::result_t                         result
);
    logic signed [temp_pkg::SAMPLE_W-1:0] whole_s;
    logic signed [temp_pkg::SAMPLE_W-1:0] shifted;

    always_comb begin
        whole_s = temp >>> temp_pkg::FRAC_BITS;
        shifted = whole_s + $signed({{(temp_pkg::SAMPLE_W-8){1'b0}}, temp_pkg::EXT_OFFSET});
        result.frac = {temp[temp_pkg::FRAC_BITS-1:0], temp_pkg::LOW_NIBBLE};
        if (extended) begin
            if (shifted < 0) begin
                result.whole = temp_pkg::ZERO_BYTE;
                result.frac  = {temp_pkg::LOW_NIBBLE, temp_pkg::LOW_NIBBLE};
            end else if (shifted > $signed({{(temp_pkg::SAMPLE_W-8){1'b0}}, temp_pkg::EXT_MAX})) begin
                result.whole = temp_pkg::EXT_MAX;
            end else begin
                result.whole = shifted[7:0];
            end
        end else begin
            if (temp < 0) begin
                result.whole = temp_pkg::ZERO_BYTE;
                result.frac  = {temp_pkg::LOW_NIBBLE, temp_pkg::LOW_NIBBLE};
            end else if (whole_s > $signed({{(temp_pkg::SAMPLE_W-8){1'b0}}, temp_pkg::STD_MAX})) begin
                result.whole = temp_pkg::STD_MAX;
            end else begin
                result.whole = whole_s[7:0];
            end
        end
    end
endmodule

/* hw/temp_avg.sv */
// Purpose: moving average of the last four or eight remote samples
// Assumes: one sample per valid pulse
// Notes: fill count cleared on level change (history kept), window refills from new samples
`timescale 1ns/10ps
module temp_avg #(
    parameter int DEPTH = temp_pkg::HIST_DEPTH
) (
    // clock and reset
    input  wire logic                                 CLK_SYS,
    input  wire logic                                 RST_B,
    // control
    input  wire logic [1:0]                           level,
    // samples
    input  temp_pkg::sample_t                         sample,
    output logic signed [temp_pkg::SAMPLE_W-1:0]      avg
);
    logic signed [temp_pkg::SAMPLE_W-1:0] hist_r   [DEPTH];
    logic signed [temp_pkg::SAMPLE_W-1:0] hist_nxt [DEPTH];
    logic [3:0]                           fill_r;
    logic [3:0]                           fill_nxt;
    logic [1:0]                           level_r;
    logic signed [temp_pkg::SAMPLE_W+3:0] sum;
    logic [3:0]                           win;

    always_comb begin
        hist_nxt = hist_r;
        fill_nxt = fill_r;
        if (level != level_r) begin
            fill_nxt = 4'h0;
        end else if (sample.valid) begin
            for (int i = DEPTH-1; i > 0; i--) begin
                hist_nxt[i] = hist_r[i-1];
            end
            hist_nxt[0] = sample.temp;
            if (fill_r < 4'(DEPTH)) begin
                fill_nxt = fill_r + 4'h1;
            end
        end
    end

    always_comb begin
        win = (level == temp_pkg::FILT_L2) ? 4'h8 : 4'h4;
        if (fill_r < win) begin
            win = (fill_r == 4'h0) ? 4'h1 : fill_r;
        end
        sum = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (4'(i) < win) begin
                sum = sum + 20'(hist_r[i]);
            end
        end
        case (win)
            4'h8:    avg = 16'(sum >>> 3);
            4'h4:    avg = 16'(sum >>> 2);
            4'h2:    avg = 16'(sum >>> 1);
            4'h1:    avg = 16'(sum);
            default: avg = 16'(sum / $signed({16'h0, win}));
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < DEPTH; i++) begin
                hist_r[i] <= '0;
            end
            fill_r  <= 4'h0;
            level_r <= temp_pkg::FILT_OFF;
        end else begin
            hist_r  <= hist_nxt;
            fill_r  <= fill_nxt;
            level_r <= level;
        end
    end
endmodule

/* hw/temp_result_filter_alert.sv */
// Purpose: result formatting, remote filter, fault flag, alert count, conversion sequencing
// Assumes: front end converts on start pulse and returns both samples with done
// Notes: register access is outside; all control is plain ports
`timescale 1ns/10ps
module temp_result_filter_alert (
    // clock and reset
    input  wire logic                                 CLK_SYS,
    input  wire logic                                 RST_B,
    // configuration
    input  wire logic                                 POWER_DOWN_CTL,
    input  wire logic                                 RANGE_EXT,
    input  wire logic [1:0]                           FILTER_LEVEL,
    input  wire logic [2:0]                           VIOLATION_COUNT_SEL,
    input  wire logic                                 ONE_SHOT_WR,
    input  wire logic signed [temp_pkg::SAMPLE_W-1:0] ALERT_LIMIT,
    input  wire logic signed [temp_pkg::SAMPLE_W-1:0] OVERTEMP_LIMIT,
    input  wire logic                                 OPEN_FLAG_CLR,
    // front end
    output logic                                      CONV_START,
    output logic                                      FRONT_POWER_EN,
    input  wire logic                                 CONV_DONE,
    input  wire logic signed [temp_pkg::SAMPLE_W-1:0] LOCAL_SAMPLE,
    input  wire logic signed [temp_pkg::SAMPLE_W-1:0] REMOTE_SAMPLE,
    input  wire logic                                 DIODE_SHORT,
    input  wire logic                                 FAULT_CMP,
    // results and status
    output temp_pkg::result_t                         LOCAL_RESULT,
    output temp_pkg::result_t                         REMOTE_RESULT,
    output logic                                      OPEN_FLAG,
    output logic                                      ALERT_OUT,
    output logic                                      OVERTEMP_OUT,
    output logic                                      BUSY
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_START = 3'b010,
        ST_CONV  = 3'b100
    } conv_state_t;

    conv_state_t state_r, state_nxt;
    logic        oneshot_r, oneshot_nxt;
    logic        range_r, range_nxt;
    logic [2:0]  fault_sync_r;
    logic        open_r, open_nxt;
    logic [2:0]  viol_r, viol_nxt;
    logic        alert_r, alert_nxt;
    logic        otemp_r, otemp_nxt;
    logic        done_d_r, done_d_nxt;
    logic        ext_d_r, ext_d_nxt;
    temp_pkg::result_t local_r, local_nxt;
    temp_pkg::result_t remote_r, remote_nxt;
    logic signed [temp_pkg::SAMPLE_W-1:0] local_d_r, local_d_nxt;
    logic signed [temp_pkg::SAMPLE_W-1:0] remote_raw;
    logic signed [temp_pkg::SAMPLE_W-1:0] remote_avg;
    logic signed [temp_pkg::SAMPLE_W-1:0] remote_filt;
    logic signed [temp_pkg::SAMPLE_W-1:0] remote_hold_r, remote_hold_nxt;
    temp_pkg::sample_t  filt_in;
    temp_pkg::result_t  local_fmt;
    temp_pkg::result_t  remote_fmt;
    logic               fault_seen;
    logic               violated;

    // count field to required run length minus one
    function automatic logic [2:0] need_count(input logic [2:0] sel);
        case (sel)
            temp_pkg::CNT_ONE:   need_count = 3'h0;
            temp_pkg::CNT_TWO:   need_count = 3'h1;
            temp_pkg::CNT_THREE: need_count = 3'h2;
            temp_pkg::CNT_FOUR:  need_count = 3'h3;
            default:             need_count = 3'h0;
        endcase
    endfunction

    // shorted diode forces the lowest extended code
    localparam logic signed [temp_pkg::SAMPLE_W-1:0] SHORT_TEMP = -16'sd1024;

    assign remote_raw = DIODE_SHORT ? SHORT_TEMP : REMOTE_SAMPLE;
    assign filt_in    = '{valid: CONV_DONE && (state_r == ST_CONV), temp: remote_raw};

    temp_avg #(
        .DEPTH (temp_pkg::HIST_DEPTH)
    ) u_avg (
        .CLK_SYS (CLK_SYS),
        .RST_B   (RST_B),
        .level   (FILTER_LEVEL),
        .sample  (filt_in),
        .avg     (remote_avg)
    );

    // filtered value valid the cycle after done, once history has the sample
    // bypass reads the held raw sample directly so the net follows it
    assign remote_filt = (FILTER_LEVEL == temp_pkg::FILT_OFF) ? remote_hold_r : remote_avg;

    temp_format u_fmt_local (
        .temp     (local_d_r),
        .extended (ext_d_r),
        .result   (local_fmt)
    );

    temp_format u_fmt_remote (
        .temp     (remote_filt),
        .extended (ext_d_r),
        .result   (remote_fmt)
    );

    assign fault_seen = fault_sync_r[1] && fault_sync_r[2];
    assign violated   = remote_filt > ALERT_LIMIT;

    // conversion sequencing
    always_comb begin
        state_nxt   = state_r;
        oneshot_nxt = oneshot_r;
        range_nxt   = range_r;
        if (ONE_SHOT_WR && POWER_DOWN_CTL && state_r == ST_IDLE) begin
            oneshot_nxt = 1'b1;
        end
        case (state_r)
            ST_IDLE: begin
                if (!POWER_DOWN_CTL || oneshot_r) begin
                    state_nxt = ST_START;
                end
            end
            ST_START: begin
                range_nxt   = RANGE_EXT;
                oneshot_nxt = 1'b0;
                state_nxt   = ST_CONV;
            end
            ST_CONV: begin
                if (CONV_DONE) begin
                    // shutdown only acts at the conversion boundary
                    state_nxt = POWER_DOWN_CTL ? ST_IDLE : ST_START;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // result, fault and limit logic
    always_comb begin
        done_d_nxt      = filt_in.valid;
        ext_d_nxt       = ext_d_r;
        local_d_nxt     = local_d_r;
        remote_hold_nxt = remote_hold_r;
        local_nxt       = local_r;
        remote_nxt      = remote_r;
        open_nxt        = open_r;
        viol_nxt        = viol_r;
        alert_nxt       = alert_r;
        otemp_nxt       = otemp_r;
        if (OPEN_FLAG_CLR) begin
            open_nxt = 1'b0;
        end
        if (state_r == ST_CONV && fault_seen) begin
            open_nxt = 1'b1;
        end
        if (filt_in.valid) begin
            local_d_nxt     = LOCAL_SAMPLE;
            remote_hold_nxt = remote_raw;
            ext_d_nxt       = range_r;
        end
        if (done_d_r) begin
            local_nxt  = local_fmt;
            remote_nxt = remote_fmt;
            otemp_nxt  = remote_filt > OVERTEMP_LIMIT;
            if (violated) begin
                if (viol_r >= need_count(VIOLATION_COUNT_SEL)) begin
                    alert_nxt = 1'b1;
                end else begin
                    viol_nxt = viol_r + 3'h1;
                end
            end else begin
                viol_nxt  = 3'h0;
                alert_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            state_r       <= ST_IDLE;
            oneshot_r     <= 1'b0;
            range_r       <= 1'b0;
            fault_sync_r  <= 3'h0;
            open_r        <= 1'b0;
            viol_r        <= 3'h0;
            alert_r       <= 1'b0;
            otemp_r       <= 1'b0;
            done_d_r      <= 1'b0;
            ext_d_r       <= 1'b0;
            local_d_r     <= '0;
            remote_hold_r <= '0;
            local_r       <= '0;
            remote_r      <= '0;
        end else begin
            state_r       <= state_nxt;
            oneshot_r     <= oneshot_nxt;
            range_r       <= range_nxt;
            fault_sync_r  <= {fault_sync_r[1:0], FAULT_CMP};
            open_r        <= open_nxt;
            viol_r        <= viol_nxt;
            alert_r       <= alert_nxt;
            otemp_r       <= otemp_nxt;
            done_d_r      <= done_d_nxt;
            ext_d_r       <= ext_d_nxt;
            local_d_r     <= local_d_nxt;
            remote_hold_r <= remote_hold_nxt;
            local_r       <= local_nxt;
            remote_r      <= remote_nxt;
        end
    end

    // front end powered only while converting; results stay readable
    assign CONV_START     = (state_r == ST_START);
    assign FRONT_POWER_EN = (state_r != ST_IDLE);
    assign BUSY           = (state_r != ST_IDLE);
    assign LOCAL_RESULT   = local_r;
    assign REMOTE_RESULT  = remote_r;
    assign OPEN_FLAG      = open_r;
    assign ALERT_OUT      = alert_r;
    assign OVERTEMP_OUT   = otemp_r;
endmodule

/* tb/temp_result_monitor.sv */
// Purpose: port checker for the temperature result back end
// Assumes: one clock, async active-low reset
// Notes: attached by bind at the foot
`timescale 1ns/10ps
module temp_result_monitor (
    // clock and reset
    input wire logic         CLK_SYS,
    input wire logic         RST_B,
    // control
    input wire logic         POWER_DOWN_CTL,
    input wire logic         ONE_SHOT_WR,
    // front end
    input wire logic         CONV_START,
    input wire logic         FRONT_POWER_EN,
    input wire logic         CONV_DONE,
    input wire logic         FAULT_CMP,
    // results
    input temp_pkg::result_t LOCAL_RESULT,
    input temp_pkg::result_t REMOTE_RESULT,
    input wire logic         OPEN_FLAG,
    input wire logic         ALERT_OUT,
    input wire logic         BUSY
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    start_chain_a: assert property (CONV_DONE && BUSY && !POWER_DOWN_CTL |=> CONV_START)
        else $error("no start after done in continuous mode");
    start_pulse_a: assert property (CONV_START |=> !CONV_START)
        else $error("start pulse longer than one cycle");
    stop_after_a: assert property (CONV_DONE && POWER_DOWN_CTL |=> !CONV_START [*8])
        else $error("conversion started in shutdown");
    idle_quiet_a: assert property (!BUSY && POWER_DOWN_CTL && !ONE_SHOT_WR && !$past(ONE_SHOT_WR)
        |=> !CONV_START)
        else $error("idle shutdown started a conversion");
    one_shot_a: assert property (ONE_SHOT_WR && POWER_DOWN_CTL && !BUSY |-> ##[1:2] CONV_START)
        else $error("one shot write ignored in shutdown");
    power_off_a: assert property (CONV_DONE && BUSY && POWER_DOWN_CTL |=> !FRONT_POWER_EN)
        else $error("front end still powered after final conversion");
    open_set_a: assert property ((FAULT_CMP && FRONT_POWER_EN) [*5] |-> ##[0:3] OPEN_FLAG)
        else $error("fault during conversion not flagged");
    result_time_a: assert property ($changed(LOCAL_RESULT) || $changed(REMOTE_RESULT)
        |-> $past(CONV_DONE, 2))
        else $error("result changed away from conversion end");
    alert_time_a: assert property ($changed(ALERT_OUT) |-> $past(CONV_DONE, 2))
        else $error("alert changed away from conversion end");
    frac_low_a: assert property (LOCAL_RESULT.frac[3:0] == 4'h0 && REMOTE_RESULT.frac[3:0] == 4'h0)
        else $error("fraction low nibble not zero");
endmodule

bind temp_result_filter_alert temp_result_monitor i_temp_result_monitor (.CLK_SYS, .RST_B,
    .POWER_DOWN_CTL, .ONE_SHOT_WR, .CONV_START, .FRONT_POWER_EN, .CONV_DONE, .FAULT_CMP,
    .LOCAL_RESULT, .REMOTE_RESULT, .OPEN_FLAG, .ALERT_OUT, .BUSY);

/* tb/front_end_model.sv */
// Purpose: behavioural remote diode and analog front end
// Assumes: answers each start after a fixed delay
// Notes: sample lines scramble once released
`timescale 1ns/10ps
module front_end_model #(
    parameter int DLY = 6
) (
    // block side
    input  wire logic               clk,
    input  wire logic               conv_start,
    input  wire logic               power_en,
    // scenario knobs
    input  wire logic signed [15:0] loc_val,
    input  wire logic signed [15:0] rem_val,
    input  wire logic               short_en,
    input  wire logic               open_en,
    // answers
    output logic                    conv_done,
    output logic signed [15:0]      loc_smp,
    output logic signed [15:0]      rem_smp,
    output logic                    short_out,
    output logic                    fault_out
);
    int   cnt;
    logic st;
    assign short_out = short_en;
    assign fault_out = open_en && power_en;
    initial begin
        conv_done = 1'b0;
        loc_smp = '0;
        rem_smp = '0;
        cnt = 0;
    end
    always @(posedge clk) begin
        st = conv_start;
        #1;
        if (conv_done) begin
            conv_done = 1'b0;
            loc_smp = ~loc_smp;
            rem_smp = ~rem_smp;
        end
        if (st) cnt = DLY;
        else if (cnt > 1) cnt--;
        else if (cnt == 1) begin
            cnt = 0;
            conv_done = 1'b1;
            loc_smp = loc_val;
            rem_smp = rem_val;
        end
    end
endmodule

/* tb/temp_result_filter_alert_bench.sv */
// Purpose: self-checking bench for the result back end
// Assumes: front end model answers every start
// Notes: each scenario judges its own outputs
`timescale 1ns/10ps
module temp_result_filter_alert_bench;
    logic               clk, rst_b, pd, rng, osw, oclr, sh, op;
    logic [1:0]         flv;
    logic [2:0]         vsel;
    logic signed [15:0] alim, olim, loc_v, rem_v, ls, rs;
    logic               start, pwr, done, dsh, fcmp, oflag, alert, ot, busy;
    temp_pkg::result_t  lres, rres;
    int                 fails, samples_checked;

    temp_result_filter_alert i_temp_result_filter_alert (.CLK_SYS(clk), .RST_B(rst_b),
        .POWER_DOWN_CTL(pd), .RANGE_EXT(rng), .FILTER_LEVEL(flv), .VIOLATION_COUNT_SEL(vsel),
        .ONE_SHOT_WR(osw), .ALERT_LIMIT(alim), .OVERTEMP_LIMIT(olim), .OPEN_FLAG_CLR(oclr),
        .CONV_START(start), .FRONT_POWER_EN(pwr), .CONV_DONE(done), .LOCAL_SAMPLE(ls),
        .REMOTE_SAMPLE(rs), .DIODE_SHORT(dsh), .FAULT_CMP(fcmp), .LOCAL_RESULT(lres),
        .REMOTE_RESULT(rres), .OPEN_FLAG(oflag), .ALERT_OUT(alert), .OVERTEMP_OUT(ot), .BUSY(busy));
    front_end_model i_front_end_model (.clk(clk), .conv_start(start), .power_en(pwr),
        .loc_val(loc_v), .rem_val(rem_v), .short_en(sh), .open_en(op), .conv_done(done),
        .loc_smp(ls), .rem_smp(rs), .short_out(dsh), .fault_out(fcmp));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] fmt(input logic signed [15:0] t, input logic x);
        int w;
        w = (t >>> 4) + (x ? 64 : 0);
        if (w < 0) return 16'h0000;
        if (!x && w > 127) return 16'h7F00;
        return {w[7:0], t[3:0], 4'h0};
    endfunction
    task automatic edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_done;
        int i;
        i = 0;
        do @(posedge clk); while (done !== 1'b1 && ++i < 200);
        if (i >= 200) begin
            fails++;
            report_and_stop();
        end else #1;
    endtask
    // samples reach the model before the conversion in flight ends
    task automatic conv(input logic signed [15:0] l, input logic signed [15:0] r);
        loc_v = l;
        rem_v = r;
        wait_done();
        edges(2);
    endtask
    task automatic count_starts(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            n += (start === 1'b1);
        end
    endtask

    task automatic t_format;
        logic signed [15:0] tv [5] = '{16'sh0198, 16'sh0001, 16'shFEC0, 16'sh0960, 16'sh07FF};
        for (int x = 0; x < 2; x++) begin
            rng = x[0];
            if (x == 1) begin
                conv(tv[0], tv[0]);
                chk("range late", rres, fmt(tv[0], 1'b0));
            end
            foreach (tv[i]) begin
                conv(tv[i], tv[i]);
                chk("local fmt", lres, fmt(tv[i], rng));
                chk("remote fmt", rres, fmt(tv[i], rng));
            end
        end
        $display("test format done");
    endtask
    task automatic t_filter;
        rng = 1'b0;
        alim = 16'sh0030;
        for (int lv = 1; lv < 3; lv++) begin
            flv = lv[1:0];
            repeat (4 * lv) conv(16'sh0010, 16'sh0010);
            conv(16'sh0010, lv == 1 ? 16'sh0050 : 16'sh0090);
            chk("filtered", rres, 16'h0200);
            chk("alert filt", alert, 1'b0);
        end
        flv = 2'h0;
        conv(16'sh0010, 16'sh0050);
        chk("unfiltered", rres, 16'h0500);
        chk("alert raw", alert, 1'b1);
        $display("test filter done");
    endtask
    task automatic t_alert;
        logic [2:0] code [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        alim = 16'sh0280;
        olim = 16'sh02D0;
        foreach (code[c]) begin
            vsel = code[c];
            repeat (c) conv(16'sh0140, 16'sh0320);
            conv(16'sh0140, 16'sh0140);
            chk("alert broken run", alert, 1'b0);
            chk("overtemp low", ot, 1'b0);
            for (int k = 0; k <= c; k++) begin
                conv(16'sh0140, 16'sh0320);
                chk("alert count", alert, k == c);
            end
            chk("overtemp high", ot, 1'b1);
        end
        $display("test alert done");
    endtask
    task automatic t_fault;
        rng = 1'b1;
        sh = 1'b1;
        repeat (2) conv(16'sh0010, 16'sh0190);
        chk("short", rres, 16'h0000);
        chk("local ext", lres, 16'h4100);
        sh = 1'b0;
        op = 1'b1;
        conv(16'sh0010, 16'sh0190);
        chk("open set", oflag, 1'b1);
        op = 1'b0;
        edges(5);
        oclr = 1'b1;
        edges(1);
        oclr = 1'b0;
        chk("open clear", oflag, 1'b0);
        $display("test fault done");
    endtask
    task automatic t_shutdown;
        int n;
        rng = 1'b0;
        rem_v = 16'sh01E0;
        pd = 1'b1;
        wait_done();
        edges(2);
        chk("last conv", rres, 16'h1E00);
        count_starts(30, n);
        chk("no starts", n[15:0], 16'h0000);
        chk("idle", busy, 1'b0);
        chk("power off", pwr, 1'b0);
        rem_v = 16'sh0230;
        osw = 1'b1;
        edges(1);
        osw = 1'b0;
        wait_done();
        edges(2);
        chk("one shot", rres, 16'h2300);
        count_starts(30, n);
        chk("one only", n[15:0], 16'h0000);
        chk("back idle", busy, 1'b0);
        pd = 1'b0;
        count_starts(60, n);
        chk("continuous", n >= 4, 1'b1);
        $display("test shutdown done");
    endtask

    initial begin
        {rst_b, pd, rng, osw, oclr, sh, op} = '0;
        flv = 2'h0;
        vsel = 3'h0;
        alim = 16'sh7FFF;
        olim = 16'sh7FFF;
        loc_v = '0;
        rem_v = '0;
        fails = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        t_format();
        t_filter();
        t_alert();
        t_fault();
        t_shutdown();
        report_and_stop();
    end
endmodule
